// file: logic/vams_selector.sv
`timescale 1ns/100ps
`default_nettype none
module vams_selector (
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // axi4-lite slave
  input wire logic [vams_pkg::VAMS_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [vams_pkg::VAMS_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // decoded embedded stream metadata
  input wire logic emb_decoding_in,
  input wire logic emb_md_valid_in,
  input wire logic [2:0] emb_md_prog_in,
  input wire logic [4:0] emb_md_idx_in,
  input wire logic [7:0] emb_md_char_in,
  input wire logic emb_fmt_valid_in,
  input wire logic [2:0] emb_fmt_prog_in,
  input wire logic [7:0] emb_fmt_in,
  input wire logic emb_fmt_alarm_in,
  input wire logic [2:0] emb_front_ch_in,
  input wire logic [1:0] emb_rear_ch_in,
  input wire logic emb_lfe_in,
  input wire logic [3:0] emb_prog_cfg_in,
  // vanc metadata packets
  input wire logic vanc_md_valid_in,
  input wire logic [7:0] vanc_did_in,
  input wire logic [7:0] vanc_sdid_in,
  input wire logic [2:0] vanc_prog_in,
  input wire logic [4:0] vanc_idx_in,
  input wire logic [7:0] vanc_char_in,
  input wire logic vanc_fmt_valid_in,
  input wire logic [7:0] vanc_fmt_in,
  input wire logic vanc_fmt_alarm_in,
  input wire logic [2:0] vanc_front_ch_in,
  input wire logic [1:0] vanc_rear_ch_in,
  input wire logic vanc_lfe_in,
  input wire logic [3:0] vanc_prog_cfg_in,
  // timing measurements
  input wire logic audio_rate_valid_in,
  input wire logic [3:0] audio_rate_in,
  input wire logic [3:0] video_rate_in,
  input wire logic preamble_valid_in,
  input wire logic [11:0] preamble_line_in,
  input wire logic [12:0] preamble_sample_in,
  input wire logic [11:0] ref_line_in,
  input wire logic [12:0] ref_sample_in,
  // outputs
  output logic [1:0] active_source_out,
  output logic rate_mismatch_out,
  output logic format_error_out,
  output logic irq_out
);
  import vams_pkg::*;

  typedef struct packed {
    logic aw_got;
    logic [VAMS_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] mode;
    logic [7:0] sdid;
    logic [2:0] prog;
    logic [VAMS_EVT_W-1:0] evt;
    logic [VAMS_EVT_W-1:0] evt_en;
    vams_src_type src;
    logic [7:0] fmt;
    logic fmt_alarm;
    logic [2:0] front_ch;
    logic [1:0] rear_ch;
    logic lfe;
    logic [3:0] prog_cfg;
    logic rate_mm;
    logic [11:0] pre_line;
    logic [12:0] pre_sample;
    logic [11:0] gb_line;
    logic [12:0] gb_sample;
    logic [VAMS_LABEL_CHARS*8-1:0] label;
  } vams_state_type;

  vams_state_type st_ff;
  vams_state_type nxt_st;

  logic vanc_hit;
  logic emb_sel;
  logic vanc_sel;
  logic wr_fire;
  logic [VAMS_ADDR_W-1:0] rd_addr;
  logic [31:0] rd_word;
  logic rd_ok;

  // packet accepted only on fixed DID and configured SDID
  assign vanc_hit = (vanc_did_in == VAMS_DID_FIXED) && (vanc_sdid_in == st_ff.sdid);

  always_comb begin
    emb_sel = 1'b0;
    vanc_sel = 1'b0;
    case (vams_mode_type'(st_ff.mode))
      VAMS_MODE_AUTO: begin
        // decided every cycle so a lost decoder falls back at once
        emb_sel = emb_decoding_in;
        vanc_sel = !emb_decoding_in;
      end
      VAMS_MODE_EMB: emb_sel = emb_decoding_in;
      VAMS_MODE_VANC: vanc_sel = 1'b1;
      default: begin
        emb_sel = 1'b0;
        vanc_sel = 1'b0;
      end
    endcase
  end

  always_comb begin
    rd_addr = st_ff.aw_addr;
    rd_addr = s_axi_araddr_in;
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    case (rd_addr)
      VAMS_OFF_CTRL: begin
        rd_word[VAMS_CTRL_MODE_LSB +: 2] = st_ff.mode;
        rd_word[VAMS_CTRL_SDID_LSB +: 8] = st_ff.sdid;
        rd_word[VAMS_CTRL_PROG_LSB +: 3] = st_ff.prog;
      end
      VAMS_OFF_STATUS: rd_word = {25'h0, st_ff.fmt_alarm, st_ff.rate_mm, 3'h0, st_ff.src};
      VAMS_OFF_EVT: rd_word = {28'h0, st_ff.evt};
      VAMS_OFF_EVT_CLR: rd_word = 32'h0000_0000;
      VAMS_OFF_EVT_EN: rd_word = {28'h0, st_ff.evt_en};
      // fmt, alarm, channel mode front/rear/lfe, program config
      VAMS_OFF_FMT: begin
        rd_word = {7'h0, st_ff.fmt_alarm, 4'h0, st_ff.prog_cfg, 2'h0, st_ff.lfe,
                   st_ff.rear_ch, st_ff.front_ch, st_ff.fmt};
      end
      VAMS_OFF_PREAMBLE: rd_word = {3'h0, st_ff.pre_sample, 4'h0, st_ff.pre_line};
      VAMS_OFF_GUARD: rd_word = {3'h0, st_ff.gb_sample, 4'h0, st_ff.gb_line};
      default: begin
        if (rd_addr >= VAMS_OFF_LABEL0 && rd_addr[1:0] == 2'b00 &&
            rd_addr < VAMS_OFF_LABEL0 + 8'(VAMS_LABEL_WORDS * 4)) begin
          rd_word = st_ff.label[32*(3'(rd_addr[4:2])) +: 32];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  assign wr_fire = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;

  always_comb begin
    logic [VAMS_EVT_W-1:0] ev_set;
    logic [VAMS_EVT_W-1:0] ev_clr;
    logic [2:0] f_ch;
    logic [1:0] r_ch;
    ev_set = '0;
    ev_clr = '0;
    f_ch = 3'h0;
    r_ch = 2'h0;
    nxt_st = st_ff;
    // write channel capture, either order
    if (s_axi_awvalid_in && !st_ff.aw_got) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_ff.w_got) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata_in;
      nxt_st.w_strb = s_axi_wstrb_in;
    end
    if (wr_fire) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = VAMS_RESP_OKAY;
      case (st_ff.aw_addr)
        VAMS_OFF_CTRL: begin
          if (st_ff.w_strb[0]) nxt_st.mode = st_ff.w_data[VAMS_CTRL_MODE_LSB +: 2];
          if (st_ff.w_strb[1]) nxt_st.sdid = st_ff.w_data[VAMS_CTRL_SDID_LSB +: 8];
          if (st_ff.w_strb[2]) nxt_st.prog = st_ff.w_data[VAMS_CTRL_PROG_LSB +: 3];
        end
        VAMS_OFF_EVT_CLR: if (st_ff.w_strb[0]) ev_clr = st_ff.w_data[VAMS_EVT_W-1:0];
        VAMS_OFF_EVT_EN: if (st_ff.w_strb[0]) nxt_st.evt_en = st_ff.w_data[VAMS_EVT_W-1:0];
        VAMS_OFF_STATUS, VAMS_OFF_EVT, VAMS_OFF_FMT, VAMS_OFF_PREAMBLE, VAMS_OFF_GUARD: begin
          nxt_st.bresp = VAMS_RESP_OKAY;
        end
        default: begin
          if (!(st_ff.aw_addr >= VAMS_OFF_LABEL0 &&
                st_ff.aw_addr < VAMS_OFF_LABEL0 + 8'(VAMS_LABEL_WORDS * 4)))
            nxt_st.bresp = VAMS_RESP_SLVERR;
        end
      endcase
    end
    if (st_ff.bvalid && s_axi_bready_in) nxt_st.bvalid = 1'b0;
    if (!st_ff.rvalid && s_axi_arvalid_in) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_word;
      nxt_st.rresp = rd_ok ? VAMS_RESP_OKAY : VAMS_RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready_in) begin
      nxt_st.rvalid = 1'b0;
    end

    // source tracking
    nxt_st.src = emb_sel ? VAMS_SRC_EMB : (vanc_sel ? VAMS_SRC_VANC : VAMS_SRC_NONE);
    if (nxt_st.src != st_ff.src) ev_set[VAMS_EVT_SRC_CHG] = 1'b1;
    if (!emb_sel && !vanc_sel) begin
      // no format, channel mode or label reported without a source; preamble and guard values hold
      nxt_st.fmt = 8'h00;
      nxt_st.fmt_alarm = 1'b0;
      nxt_st.front_ch = 3'h0;
      nxt_st.rear_ch = 2'h0;
      nxt_st.lfe = 1'b0;
      nxt_st.prog_cfg = 4'h0;
      nxt_st.label = '0;
    end
    if (emb_sel && emb_md_valid_in && emb_md_prog_in == st_ff.prog) begin
      nxt_st.label[8*emb_md_idx_in +: 8] = emb_md_char_in;
      ev_set[VAMS_EVT_LABEL] = 1'b1;
    end
    if (vanc_sel && vanc_hit && vanc_md_valid_in && vanc_prog_in == st_ff.prog) begin
      nxt_st.label[8*vanc_idx_in +: 8] = vanc_char_in;
      ev_set[VAMS_EVT_LABEL] = 1'b1;
    end
    if (emb_sel && emb_fmt_valid_in && emb_fmt_prog_in == st_ff.prog) begin
      nxt_st.fmt = emb_fmt_in;
      nxt_st.fmt_alarm = emb_fmt_alarm_in;
      f_ch = emb_front_ch_in;
      r_ch = emb_rear_ch_in;
      nxt_st.front_ch = f_ch;
      nxt_st.rear_ch = r_ch;
      nxt_st.lfe = emb_lfe_in;
      nxt_st.prog_cfg = emb_prog_cfg_in;
    end
    if (vanc_sel && vanc_hit && vanc_fmt_valid_in && vanc_prog_in == st_ff.prog) begin
      nxt_st.fmt = vanc_fmt_in;
      nxt_st.fmt_alarm = vanc_fmt_alarm_in;
      f_ch = vanc_front_ch_in;
      r_ch = vanc_rear_ch_in;
      nxt_st.front_ch = f_ch;
      nxt_st.rear_ch = r_ch;
      nxt_st.lfe = vanc_lfe_in;
      nxt_st.prog_cfg = vanc_prog_cfg_in;
    end
    // level flag, follows live rates while measured and the embedded source is selected
    nxt_st.rate_mm = audio_rate_valid_in && emb_sel && (audio_rate_in != video_rate_in);
    if (nxt_st.rate_mm && !st_ff.rate_mm) ev_set[VAMS_EVT_RATE_MM] = 1'b1;
    if (nxt_st.fmt_alarm && !st_ff.fmt_alarm) ev_set[VAMS_EVT_FMT_ALM] = 1'b1;
    if (preamble_valid_in && emb_sel) begin
      nxt_st.pre_line = preamble_line_in;
      nxt_st.pre_sample = preamble_sample_in;
      nxt_st.gb_line = ref_line_in;
      nxt_st.gb_sample = ref_sample_in;
    end
    // set beats clear in the same cycle
    nxt_st.evt = (st_ff.evt & ~ev_clr) | ev_set;
    if (srst_in) begin
      nxt_st = '0;
      nxt_st.mode = VAMS_MODE_AUTO;
      nxt_st.sdid = VAMS_SDID_RST;
      nxt_st.prog = VAMS_PROG_RST;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st_ff <= nxt_st;
  end

  assign s_axi_awready_out = !st_ff.aw_got;
  assign s_axi_wready_out = !st_ff.w_got;
  assign s_axi_bvalid_out = st_ff.bvalid;
  assign s_axi_bresp_out = st_ff.bresp;
  assign s_axi_arready_out = !st_ff.rvalid;
  assign s_axi_rvalid_out = st_ff.rvalid;
  assign s_axi_rdata_out = st_ff.rdata;
  assign s_axi_rresp_out = st_ff.rresp;
  assign active_source_out = st_ff.src;
  assign rate_mismatch_out = st_ff.rate_mm;
  assign format_error_out = st_ff.fmt_alarm;
  assign irq_out = |(st_ff.evt & st_ff.evt_en);

  AST_AUTO_EMB: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st_ff.mode == VAMS_MODE_AUTO && emb_decoding_in) |=> active_source_out == VAMS_SRC_EMB)
    else $error("auto mode did not pick decoded stream");
  AST_AUTO_VANC: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st_ff.mode == VAMS_MODE_AUTO && !emb_decoding_in) |=> active_source_out == VAMS_SRC_VANC)
    else $error("auto mode did not fall back to vanc");
  AST_EMB_BLANK: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st_ff.mode == VAMS_MODE_EMB && !emb_decoding_in)
    |=> (st_ff.label == '0 && st_ff.fmt == 8'h00))
    else $error("embedded mode reported data without decoding");
  AST_VANC_SDID: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st_ff.mode == VAMS_MODE_VANC && vanc_md_valid_in && vanc_sdid_in != st_ff.sdid
     && !$past(srst_in) && $stable(st_ff.mode))
    |=> $stable(st_ff.label))
    else $error("label took a packet with wrong sdid");
  AST_DID: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (st_ff.mode == VAMS_MODE_VANC && vanc_fmt_valid_in && vanc_did_in != VAMS_DID_FIXED
     && !vanc_md_valid_in) |=> $stable(st_ff.fmt))
    else $error("format taken from packet with wrong did");
  AST_RATE: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (emb_sel && audio_rate_valid_in && audio_rate_in != video_rate_in) |=> rate_mismatch_out)
    else $error("frame rate mismatch not flagged");
  AST_RATE_CLR: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (!audio_rate_valid_in || audio_rate_in == video_rate_in) |=> !rate_mismatch_out)
    else $error("mismatch flag did not drop");
  AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    $rose(format_error_out) |-> st_ff.evt[VAMS_EVT_FMT_ALM])
    else $error("format alarm event not latched");
endmodule : vams_selector
`default_nettype wire

// file: common/vams_pkg.sv
package vams_pkg;
  localparam int unsigned VAMS_DATA_W = 32;
  localparam int unsigned VAMS_ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] VAMS_OFF_CTRL = 8'h00;
  localparam logic [7:0] VAMS_OFF_STATUS = 8'h04;
  localparam logic [7:0] VAMS_OFF_EVT = 8'h08;
  localparam logic [7:0] VAMS_OFF_EVT_CLR = 8'h0c;
  localparam logic [7:0] VAMS_OFF_EVT_EN = 8'h10;
  localparam logic [7:0] VAMS_OFF_FMT = 8'h14;
  localparam logic [7:0] VAMS_OFF_PREAMBLE = 8'h18;
  localparam logic [7:0] VAMS_OFF_GUARD = 8'h1c;
  localparam logic [7:0] VAMS_OFF_LABEL0 = 8'h20;
  localparam int unsigned VAMS_LABEL_CHARS = 32;
  localparam int unsigned VAMS_LABEL_WORDS = 8;
  // ctrl fields
  localparam int unsigned VAMS_CTRL_MODE_LSB = 0;
  localparam int unsigned VAMS_CTRL_SDID_LSB = 8;
  localparam int unsigned VAMS_CTRL_PROG_LSB = 16;
  localparam logic [7:0] VAMS_DID_FIXED = 8'h45;
  localparam logic [7:0] VAMS_SDID_NO_ASSOC = 8'h01;
  localparam logic [7:0] VAMS_SDID_PAIR_BASE = 8'h02;
  localparam logic [7:0] VAMS_SDID_PAIR_LAST = 8'h09;
  localparam logic [7:0] VAMS_SDID_RST = 8'h01;
  localparam logic [2:0] VAMS_PROG_RST = 3'h0;
  localparam int unsigned VAMS_MAX_PROG_CH = 8;
  // event bits
  localparam int unsigned VAMS_EVT_W = 4;
  localparam int unsigned VAMS_EVT_SRC_CHG = 0;
  localparam int unsigned VAMS_EVT_RATE_MM = 1;
  localparam int unsigned VAMS_EVT_FMT_ALM = 2;
  localparam int unsigned VAMS_EVT_LABEL = 3;
  localparam logic [1:0] VAMS_RESP_OKAY = 2'b00;
  localparam logic [1:0] VAMS_RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    VAMS_MODE_AUTO = 2'h0,
    VAMS_MODE_EMB = 2'h1,
    VAMS_MODE_VANC = 2'h2
  } vams_mode_type;
  typedef enum logic [1:0] {
    VAMS_SRC_NONE = 2'h0,
    VAMS_SRC_EMB = 2'h1,
    VAMS_SRC_VANC = 2'h3
  } vams_src_type;
endpackage : vams_pkg

// file: dv/vams_anc_src.sv
`timescale 1ns/100ps
`default_nettype none
// far-side extractor and decoder; port names follow the selector's inputs
module vams_anc_src (
  input wire logic sys_clk_in,
  output logic emb_md_valid_in,
  output logic [2:0] emb_md_prog_in,
  output logic [4:0] emb_md_idx_in,
  output logic [7:0] emb_md_char_in,
  output logic emb_fmt_valid_in,
  output logic [2:0] emb_fmt_prog_in,
  output logic [7:0] emb_fmt_in,
  output logic emb_fmt_alarm_in,
  output logic [2:0] emb_front_ch_in,
  output logic [1:0] emb_rear_ch_in,
  output logic emb_lfe_in,
  output logic [3:0] emb_prog_cfg_in,
  output logic vanc_md_valid_in,
  output logic [7:0] vanc_did_in,
  output logic [7:0] vanc_sdid_in,
  output logic [2:0] vanc_prog_in,
  output logic [4:0] vanc_idx_in,
  output logic [7:0] vanc_char_in,
  output logic vanc_fmt_valid_in,
  output logic [7:0] vanc_fmt_in,
  output logic vanc_fmt_alarm_in,
  output logic [2:0] vanc_front_ch_in,
  output logic [1:0] vanc_rear_ch_in,
  output logic vanc_lfe_in,
  output logic [3:0] vanc_prog_cfg_in
);
  initial begin
    {emb_md_valid_in, emb_fmt_valid_in, vanc_md_valid_in, vanc_fmt_valid_in} = 4'h0;
    {emb_md_prog_in, emb_md_idx_in, emb_md_char_in} = '0;
    {vanc_did_in, vanc_sdid_in, vanc_prog_in, vanc_idx_in, vanc_char_in} = '0;
    {emb_fmt_prog_in, emb_fmt_in, emb_fmt_alarm_in, emb_front_ch_in} = '0;
    {emb_rear_ch_in, emb_lfe_in, emb_prog_cfg_in} = '0;
    {vanc_fmt_in, vanc_fmt_alarm_in, vanc_front_ch_in, vanc_rear_ch_in} = '0;
    {vanc_lfe_in, vanc_prog_cfg_in} = '0;
  end

  // one-cycle packet; released fields flip so a stale value never passes for data
  task automatic md(input logic v, input logic [7:0] did, input logic [7:0] sd,
                    input logic [2:0] p, input logic [4:0] i, input logic [7:0] c);
    @(posedge sys_clk_in);
    {vanc_md_valid_in, emb_md_valid_in} <= {v, !v};
    {vanc_did_in, vanc_sdid_in} <= {did, sd};
    {vanc_prog_in, vanc_idx_in, vanc_char_in} <= {p, i, c};
    {emb_md_prog_in, emb_md_idx_in, emb_md_char_in} <= {p, i, c};
    @(posedge sys_clk_in);
    {vanc_md_valid_in, emb_md_valid_in} <= 2'h0;
    {vanc_did_in, vanc_sdid_in, vanc_prog_in, vanc_idx_in, vanc_char_in} <= ~{did, sd, p, i, c};
    {emb_md_prog_in, emb_md_idx_in, emb_md_char_in} <= ~{p, i, c};
  endtask : md

  // programs sit on consecutive pairs, so the first pair alone names them
  task automatic fm(input logic v, input logic [7:0] did, input logic [7:0] sd,
                    input logic [2:0] p, input logic [18:0] f);
    @(posedge sys_clk_in);
    {vanc_fmt_valid_in, emb_fmt_valid_in} <= {v, !v};
    {vanc_did_in, vanc_sdid_in, vanc_prog_in} <= {did, sd, p};
    {emb_fmt_prog_in, emb_fmt_in, emb_fmt_alarm_in, emb_front_ch_in} <= {p, f[18:7]};
    {emb_rear_ch_in, emb_lfe_in, emb_prog_cfg_in} <= f[6:0];
    {vanc_fmt_in, vanc_fmt_alarm_in, vanc_front_ch_in, vanc_rear_ch_in} <= f[18:5];
    {vanc_lfe_in, vanc_prog_cfg_in} <= f[4:0];
    @(posedge sys_clk_in);
    {vanc_fmt_valid_in, emb_fmt_valid_in} <= 2'h0;
    {emb_fmt_in, vanc_fmt_in} <= ~{f[18:11], f[18:11]};
    {vanc_did_in, vanc_sdid_in, vanc_prog_in} <= ~{did, sd, p};
  endtask : fm
endmodule : vams_anc_src
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define VAMS_CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_top;
  import vams_pkg::*;
  logic sys_clk_in, srst_in, emb_decoding_in, audio_rate_valid_in, preamble_valid_in;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, emb_md_char_in, emb_fmt_in, vanc_did_in;
  logic [7:0] vanc_sdid_in, vanc_char_in, vanc_fmt_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, q;
  logic [3:0] s_axi_wstrb_in, audio_rate_in, video_rate_in, emb_prog_cfg_in, vanc_prog_cfg_in;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, active_source_out, emb_rear_ch_in;
  logic [1:0] vanc_rear_ch_in, rsp;
  logic rate_mismatch_out, format_error_out, irq_out, emb_md_valid_in, emb_fmt_valid_in;
  logic emb_fmt_alarm_in, emb_lfe_in, vanc_md_valid_in, vanc_fmt_valid_in, vanc_fmt_alarm_in;
  logic vanc_lfe_in;
  logic [2:0] emb_md_prog_in, emb_fmt_prog_in, emb_front_ch_in, vanc_prog_in, vanc_front_ch_in;
  logic [4:0] emb_md_idx_in, vanc_idx_in;
  logic [11:0] preamble_line_in, ref_line_in;
  logic [12:0] preamble_sample_in, ref_sample_in;
  logic [7:0] lbl [32];
  logic [18:0] f;
  logic [7:0] c, sd;
  integer seed;
  int err_count, checks_done;

  vams_selector uut (.*);
  vams_anc_src src (.*);

  initial begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [31:0] ctrl_w(input logic [1:0] m, input logic [7:0] s,
                                         input logic [2:0] p);
    return {13'h0, p, s, 6'h0, m};
  endfunction : ctrl_w

  function automatic logic [7:0] sdid_of(input int pair);
    return 8'(pair + 1);
  endfunction : sdid_of

  function automatic logic [1:0] exp_src(input int m, input logic d);
    case (m)
      0: return d ? VAMS_SRC_EMB : VAMS_SRC_VANC;
      1: return d ? VAMS_SRC_EMB : VAMS_SRC_NONE;
      2: return VAMS_SRC_VANC;
      default: return VAMS_SRC_NONE;
    endcase
  endfunction : exp_src

  function automatic logic [31:0] lw(input int n);
    return {lbl[4 * n + 3], lbl[4 * n + 2], lbl[4 * n + 1], lbl[4 * n]};
  endfunction : lw

  // format word: fmt, front, rear, lfe, program config, alarm at bit 24
  function automatic logic [31:0] exp_fmt(input logic [18:0] v);
    return {7'h0, v[10], 4'h0, v[3:0], 2'h0, v[4], v[6:5], v[9:7], v[18:11]};
  endfunction : exp_fmt

  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic [1:0] rr);
    logic [2:0] hs;
    logic done;
    @(posedge sys_clk_in);
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} <= {a, a, d};
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= {3{we}};
    {s_axi_arvalid_in, s_axi_rready_in} <= {2{!we}};
    done = 1'b0;
    while (!done) begin
      @(negedge sys_clk_in);
      hs = {s_axi_awvalid_in & s_axi_awready_out, s_axi_wvalid_in & s_axi_wready_out,
            s_axi_arvalid_in & s_axi_arready_out};
      done = we ? s_axi_bvalid_out === 1'b1 : s_axi_rvalid_out === 1'b1;
      rq = s_axi_rdata_out;
      rr = we ? s_axi_bresp_out : s_axi_rresp_out;
      @(posedge sys_clk_in);
      if (hs[2]) s_axi_awvalid_in <= 1'b0;
      if (hs[1]) s_axi_wvalid_in <= 1'b0;
      if (hs[0]) s_axi_arvalid_in <= 1'b0;
    end
    {s_axi_bready_in, s_axi_rready_in} <= 2'h0;
  endtask : acc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, q, rsp);
    `VAMS_CHK("bresp", VAMS_RESP_OKAY, rsp)
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, q, rsp);
    `VAMS_CHK("reg", e, q)
  endtask : rchk

  task automatic fill(input logic v, input logic [7:0] s, input logic [2:0] p);
    for (int i = 0; i < 32; i++) begin
      lbl[i] = 8'($random(seed));
      src.md(v, VAMS_DID_FIXED, s, p, 5'(i), lbl[i]);
    end
    repeat (3) @(posedge sys_clk_in);
    for (int n = 0; n < 8; n++) rchk(VAMS_OFF_LABEL0 + 8'(4 * n), lw(n));
  endtask : fill

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    summarize();
  end

  initial begin
    seed = 32'h5de1ecab;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in} = 4'h0;
    {s_axi_rready_in, emb_decoding_in, audio_rate_valid_in, preamble_valid_in} = 4'h0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, audio_rate_in, video_rate_in} = '0;
    {preamble_line_in, preamble_sample_in, ref_line_in, ref_sample_in} = '0;
    s_axi_wstrb_in = 4'hf;
    srst_in = 1'b1;
    repeat (3) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    rchk(VAMS_OFF_CTRL, ctrl_w(VAMS_MODE_AUTO, VAMS_SDID_RST, VAMS_PROG_RST));
    acc(1'b0, 8'h40, 32'h0, q, rsp);
    `VAMS_CHK("unmapped", VAMS_RESP_SLVERR, rsp)
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        wr(VAMS_OFF_CTRL, ctrl_w(2'(m), VAMS_SDID_NO_ASSOC, 3'h0));
        emb_decoding_in <= d[0];
        repeat (3) @(posedge sys_clk_in);
        `VAMS_CHK("src", exp_src(m, d[0]), active_source_out)
      end
    end
    wr(VAMS_OFF_CTRL, ctrl_w(VAMS_MODE_VANC, VAMS_SDID_NO_ASSOC, 3'h0));
    fill(1'b1, VAMS_SDID_NO_ASSOC, 3'h0);
    // accepted packet first, so a wrongly taken reject overwrites it
    for (int pair = 1; pair < 9; pair++) begin
      sd = sdid_of(pair);
      c = 8'($random(seed));
      wr(VAMS_OFF_CTRL, ctrl_w(VAMS_MODE_VANC, sd, 3'h0));
      src.md(1'b1, VAMS_DID_FIXED, sd, 3'h0, 5'(pair * 3), c);
      lbl[pair * 3] = c;
      src.md(1'b1, 8'h44, sd, 3'h0, 5'(pair * 3), ~c);
      src.md(1'b1, VAMS_DID_FIXED, sd + 8'h01, 3'h0, 5'(pair * 3), ~c);
      repeat (3) @(posedge sys_clk_in);
      rchk(VAMS_OFF_LABEL0 + 8'((pair * 3) / 4 * 4), lw((pair * 3) / 4));
    end
    emb_decoding_in <= 1'b1;
    wr(VAMS_OFF_CTRL, ctrl_w(VAMS_MODE_EMB, VAMS_SDID_NO_ASSOC, 3'h2));
    fill(1'b0, VAMS_SDID_NO_ASSOC, 3'h2);
    src.md(1'b0, VAMS_DID_FIXED, VAMS_SDID_NO_ASSOC, 3'h3, 5'h0, ~lbl[0]);
    repeat (3) @(posedge sys_clk_in);
    rchk(VAMS_OFF_LABEL0, lw(0));
    audio_rate_valid_in <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      c = 8'($random(seed));
      audio_rate_in <= c[3:0];
      video_rate_in <= c[3:0] ^ {3'h0, k[0]};
      repeat (3) @(posedge sys_clk_in);
      `VAMS_CHK("rate_mm", k[0], rate_mismatch_out)
    end
    for (int k = 0; k < 2; k++) begin
      f = 19'($random(seed));
      f[10] = (k == 0);
      f[9] = 1'b0;
      if (f[6:5] == 2'h3) f[6:5] = 2'h2;
      src.fm(1'b0, VAMS_DID_FIXED, VAMS_SDID_NO_ASSOC, 3'h2, f);
      repeat (3) @(posedge sys_clk_in);
      `VAMS_CHK("fmt_err", f[10], format_error_out)
      rchk(VAMS_OFF_FMT, exp_fmt(f));
      // last rate pair above differs, so the mismatch level still stands
      rchk(VAMS_OFF_STATUS, {25'h0, f[10], 1'b1, 3'h0, VAMS_SRC_EMB});
    end
    {preamble_line_in, ref_line_in} <= 24'($random(seed));
    {preamble_sample_in, ref_sample_in} <= 26'($random(seed));
    preamble_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    preamble_valid_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rchk(VAMS_OFF_PREAMBLE, {3'h0, preamble_sample_in, 4'h0, preamble_line_in});
    rchk(VAMS_OFF_GUARD, {3'h0, ref_sample_in, 4'h0, ref_line_in});
    wr(VAMS_OFF_EVT_EN, 32'h1 << VAMS_EVT_LABEL);
    wr(VAMS_OFF_EVT_CLR, 32'hf);
    repeat (2) @(posedge sys_clk_in);
    `VAMS_CHK("irq_clr", 1'b0, irq_out)
    for (int k = 0; k < 2; k++) begin
      src.md(1'b0, VAMS_DID_FIXED, VAMS_SDID_NO_ASSOC, 3'h2, 5'h7, 8'h41);
      repeat (3) @(posedge sys_clk_in);
      `VAMS_CHK("irq", k == 0, irq_out)
      acc(1'b0, VAMS_OFF_EVT, 32'h0, q, rsp);
      `VAMS_CHK("evt", 1'b1, q[VAMS_EVT_LABEL])
      wr(VAMS_OFF_EVT_CLR, 32'h1 << VAMS_EVT_LABEL);
      wr(VAMS_OFF_EVT_EN, 32'h0);
    end
    // vanc format path; a wrong-DID packet right after must not replace it
    wr(VAMS_OFF_CTRL, ctrl_w(VAMS_MODE_VANC, sdid_of(4), 3'h2));
    f[10] = 1'b1;
    src.fm(1'b1, VAMS_DID_FIXED, sdid_of(4), 3'h2, f);
    src.fm(1'b1, 8'h44, sdid_of(4), 3'h2, ~f);
    repeat (3) @(posedge sys_clk_in);
    `VAMS_CHK("vanc_fmt_err", 1'b1, format_error_out)
    rchk(VAMS_OFF_FMT, exp_fmt(f));
    summarize();
  end
endmodule : tb_top
`default_nettype wire
